// file: verilog/cmd_decoder_defs.vh
// Constants of the serial command decoder
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH

// =====================================
// Opcodes
`define OP_RESET      8'h06
`define OP_START      8'h08
`define OP_STOP       8'h0A
`define OP_READ_DATA  8'h12
`define OP_SYS_OFS    8'h16
`define OP_GAIN_CAL   8'h17
`define OP_SELF_OFS   8'h19
`define OP_REG_BASE   3'h1
`define OP_REG_TOP    7:5
`define OP_REG_ADDR   4:0

// =====================================
// Fill bytes and limits
`define BYTE_IDLE     8'hFF
`define BYTE_ZERO     8'h00
`define REG_COUNT     5'h13
`define LEN_STATUS    3'h4
`define LEN_DATA      3'h3
`define LEN_REG       3'h1

// =====================================
// Check code
`define CRC_POLY      8'h07
`define CRC_PRESET    8'hFF

// =====================================
// Reset values
`define RST_BYTE      8'h00
`define RST_WORD      24'h000000
`define RST_SEQ       40'h0000000000

`endif

// file: verilog/serial_cmd_decoder.v
// Serial command decoder with optional check-code framing
// Functional notes
// - opcode 06h resets converter and registers
// - opcode 08h starts conversions
// - opcode 0Ah stops conversions
// - send FFh, echo1, then echo2, CRC
// - buffered result readable anytime by 12h
// - colliding read gets old or new
// - data answer three to five bytes
// - no CRC: status opt, data MSB first
// - CRC on: data then CRC over payload
// - opcode 16h starts system offset cal
// - opcode 17h starts gain calibration
// - opcode 19h starts self offset cal
// - low five opcode bits address register
// - one register byte per read command
// - register byte shifted MSB first
// - unimplemented register reads as 00h
// - CRC on: register byte five, CRC six
// - CRC poly 07h, preset all ones
// - bad CRC: no exec, inverted CRC
// - execute after byte 2 or 4
`timescale 1ns/1ns
`default_nettype none
`include "cmd_decoder_defs.vh"

module serial_cmd_decoder (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Serial link pins
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        din,
  output reg         serial_out_ready,
  // Configuration levels
  input  wire        check_framing_enable,
  input  wire        status_enable,
  input  wire        check_error_clear,
  // Converter side
  input  wire        conv_done,
  input  wire [23:0] conv_data,
  input  wire [7:0]  status_byte,
  // Register file side
  output reg  [4:0]  reg_rd_addr,
  input  wire [7:0]  reg_rd_data,
  // Command results
  output reg         dev_reset_pulse,
  output reg         converting,
  output reg         system_offset_cal_cmd,
  output reg         gain_cal_cmd,
  output reg         self_offset_cal_cmd,
  output reg         check_error_flag
);

  // =====================================
  // Phases of a frame
  localparam PH_CMD  = 1'b0;
  localparam PH_DATA = 1'b1;

  // Pin synchronisers
  reg        cs_s1_r;        // First stage, read by second only
  reg        cs_s2_r;        // Stable chip select
  reg        sck_s1_r;       // First stage
  reg        sck_s2_r;       // Stable link clock
  reg        sck_s3_r;       // Delayed for edge find
  reg        din_s1_r;       // First stage
  reg        din_s2_r;       // Stable data in
  // Frame state
  reg        phase_r;        // Command or data phase
  reg [2:0]  bit_r;          // Bits received in byte
  reg [1:0]  idx_r;          // Command byte index
  reg [7:0]  rx_r;           // Receive shifter
  reg [7:0]  tx_r;           // Transmit shifter
  reg [7:0]  op_r;           // First command byte
  reg [7:0]  crc_r;          // Check code of command
  reg        crc_ok_r;       // Received code matched
  reg [39:0] seq_r;          // Pending answer bytes
  reg [2:0]  rem_r;          // Answer bytes left
  reg [23:0] buf_r;          // Latest result
  reg        drdy_n_r;       // Low when new result
  wire       sck_rise;       // Link clock rising
  wire       sck_fall;       // Link clock falling
  wire [7:0] rx_byte;        // Completed byte
  wire       byte_done;      // Eighth bit taken
  assign sck_rise  = sck_s2_r & ~sck_s3_r;
  assign sck_fall  = ~sck_s2_r & sck_s3_r;
  assign rx_byte   = {rx_r[6:0], din_s2_r};
  assign byte_done = sck_fall & (bit_r == 3'h7);

  // =====================================
  // Check code over one byte, MSB first
  function [7:0] crc8;
    input [7:0] c_in;
    input [7:0] b;
    integer i;
    reg [7:0] c;
    begin
      c = c_in;
      for (i = 7; i >= 0; i = i - 1) begin
        c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
      end
      crc8 = c;
    end
  endfunction

  // =====================================
  // Answer builder at execute time
  reg [31:0] pay;            // Payload bytes
  reg [2:0]  len;            // Payload length
  reg [7:0]  ocrc;           // Output check code
  reg [39:0] seq_nxt;        // Answer sequence
  reg [2:0]  rem_nxt;        // Answer length
  reg [7:0]  regb;           // Register byte
  always @* begin
    pay     = 32'h00000000;
    len     = 3'h0;
    ocrc    = `CRC_PRESET;
    seq_nxt = `RST_SEQ;
    rem_nxt = 3'h0;
    // Out-of-range register reads as zero
    regb = (op_r[`OP_REG_ADDR] < `REG_COUNT) ? reg_rd_data : `BYTE_ZERO;
    if (op_r == `OP_READ_DATA) begin
      // Whole buffered word, never mixed
      if (status_enable) begin
        pay = {status_byte, buf_r};
        len = `LEN_STATUS;
      end else begin
        pay = {buf_r, `BYTE_ZERO};
        len = `LEN_DATA;
      end
    end else if (op_r[`OP_REG_TOP] == `OP_REG_BASE) begin
      pay = {regb, 24'h000000};
      len = `LEN_REG;
    end
    // Code over payload bytes only
    if (len != 3'h0) begin
      ocrc = crc8(ocrc, pay[31:24]);
    end
    if (len > 3'h1) begin
      ocrc = crc8(ocrc, pay[23:16]);
      ocrc = crc8(ocrc, pay[15:8]);
    end
    if (len > 3'h3) begin
      ocrc = crc8(ocrc, pay[7:0]);
    end
    // Append code after payload when framed
    if (check_framing_enable) begin
      case (len)
        `LEN_STATUS: seq_nxt = {pay, ocrc};
        `LEN_DATA:   seq_nxt = {pay[31:8], ocrc, `BYTE_ZERO};
        `LEN_REG:    seq_nxt = {pay[31:24], ocrc, 24'h000000};
        default:     seq_nxt = `RST_SEQ;
      endcase
      rem_nxt = (len == 3'h0) ? 3'h0 : len + 3'h1;
    end else begin
      seq_nxt = {pay, `BYTE_ZERO};
      rem_nxt = len;
    end
  end

  // =====================================
  // Pin synchronisers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end else begin
      cs_s1_r  <= cs_n;
      cs_s2_r  <= cs_s1_r;
      sck_s1_r <= sclk;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      din_s1_r <= din;
      din_s2_r <= din_s1_r;
    end
  end

  // =====================================
  // Result buffer; ready indicator is kept in the frame engine
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buf_r <= `RST_WORD;
    end else if (conv_done) begin
      buf_r <= conv_data;
    end
  end

  // =====================================
  // Frame engine
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r               <= PH_CMD;
      bit_r                 <= 3'h0;
      idx_r                 <= 2'h0;
      rx_r                  <= `RST_BYTE;
      tx_r                  <= `BYTE_IDLE;
      op_r                  <= `RST_BYTE;
      crc_r                 <= `CRC_PRESET;
      crc_ok_r              <= 1'b0;
      seq_r                 <= `RST_SEQ;
      rem_r                 <= 3'h0;
      drdy_n_r              <= 1'b1;
      serial_out_ready      <= 1'b1;
      reg_rd_addr           <= 5'h00;
      dev_reset_pulse       <= 1'b0;
      converting            <= 1'b0;
      system_offset_cal_cmd <= 1'b0;
      gain_cal_cmd          <= 1'b0;
      self_offset_cal_cmd   <= 1'b0;
      check_error_flag      <= 1'b0;
    end else begin
      // Default: command pulses last one cycle
      dev_reset_pulse       <= 1'b0;
      system_offset_cal_cmd <= 1'b0;
      gain_cal_cmd          <= 1'b0;
      self_offset_cal_cmd   <= 1'b0;
      if (conv_done) begin
        drdy_n_r <= 1'b0;
      end
      if (check_error_clear) begin
        check_error_flag <= 1'b0;
      end
      if (cs_s2_r) begin
        // Deselected: abort and rearm frame
        phase_r          <= PH_CMD;
        bit_r            <= 3'h0;
        idx_r            <= 2'h0;
        rem_r            <= 3'h0;
        tx_r             <= `BYTE_IDLE;
        serial_out_ready <= drdy_n_r;
      end else begin
        // Launch next bit on rising edge
        if (sck_rise) begin
          serial_out_ready <= tx_r[7];
          tx_r             <= {tx_r[6:0], 1'b0};
        end
        // Sample input on falling edge
        if (sck_fall) begin
          rx_r  <= rx_byte;
          bit_r <= bit_r + 3'h1;
        end
        if (byte_done && phase_r == PH_DATA) begin
          // Stream answer bytes, then new frame
          if (rem_r == 3'h0) begin
            phase_r <= PH_CMD;
            idx_r   <= 2'h0;
            tx_r    <= `BYTE_IDLE;
          end else begin
            tx_r  <= seq_r[39:32];
            seq_r <= {seq_r[31:0], `BYTE_ZERO};
            rem_r <= rem_r - 3'h1;
          end
        end else if (byte_done) begin
          case (idx_r)
            2'h0: begin
              // Opcode taken, echo it back
              op_r        <= rx_byte;
              reg_rd_addr <= rx_byte[`OP_REG_ADDR];
              tx_r        <= rx_byte;
              crc_r       <= crc8(`CRC_PRESET, rx_byte);
              idx_r       <= 2'h1;
            end
            2'h1: begin
              crc_r <= crc8(crc_r, rx_byte);
              if (check_framing_enable) begin
                tx_r  <= rx_byte;
                idx_r <= 2'h2;
              end else begin
                idx_r <= 2'h0;
                if (rem_nxt == 3'h0) begin
                  tx_r <= `BYTE_IDLE;
                end else begin
                  tx_r    <= seq_nxt[39:32];
                  seq_r   <= {seq_nxt[31:0], `BYTE_ZERO};
                  rem_r   <= rem_nxt - 3'h1;
                  phase_r <= PH_DATA;
                end
              end
            end
            2'h2: begin
              // Compare host code, answer own code
              crc_ok_r <= (rx_byte == crc_r);
              tx_r     <= (rx_byte == crc_r) ? crc_r : ~crc_r;
              idx_r    <= 2'h3;
            end
            default: begin
              idx_r <= 2'h0;
              if (!crc_ok_r || rem_nxt == 3'h0) begin
                tx_r <= `BYTE_IDLE;
              end else begin
                tx_r    <= seq_nxt[39:32];
                seq_r   <= {seq_nxt[31:0], `BYTE_ZERO};
                rem_r   <= rem_nxt - 3'h1;
                phase_r <= PH_DATA;
              end
            end
          endcase
        end
        // Execute on last command byte if valid
        if (byte_done && phase_r == PH_CMD &&
            ((idx_r == 2'h1 && !check_framing_enable) ||
             (idx_r == 2'h3 && crc_ok_r))) begin
          case (op_r)
            `OP_RESET: begin
              dev_reset_pulse  <= 1'b1;
              converting       <= 1'b0;
              check_error_flag <= 1'b0;
            end
            `OP_START:    converting            <= 1'b1;
            `OP_STOP:     converting            <= 1'b0;
            `OP_SYS_OFS:  system_offset_cal_cmd <= 1'b1;
            `OP_GAIN_CAL: gain_cal_cmd          <= 1'b1;
            `OP_SELF_OFS: self_offset_cal_cmd   <= 1'b1;
            `OP_READ_DATA: begin
              if (!conv_done) begin
                drdy_n_r <= 1'b1;
              end
            end
            default: ;
          endcase
        end
        // Mismatch flag; set wins over clear
        if (byte_done && phase_r == PH_CMD && idx_r == 2'h2 &&
            rx_byte != crc_r) begin
          check_error_flag <= 1'b1;
        end
      end
    end
  end
endmodule // serial_cmd_decoder
`default_nettype wire

// file: testbench/serial_cmd_decoder_props.sv
// Checker on the serial command decoder ports
`timescale 1ns/1ns
`default_nettype none
module cmd_decoder_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link and levels
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out_ready,
  input wire logic check_framing_enable,
  input wire logic check_error_clear,
  input wire logic conv_done,
  // Command results
  input wire logic dev_reset_pulse,
  input wire logic converting,
  input wire logic system_offset_cal_cmd,
  input wire logic gain_cal_cmd,
  input wire logic self_offset_cal_cmd,
  input wire logic check_error_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Any executed command pulse
  wire logic any_p = dev_reset_pulse | system_offset_cal_cmd | gain_cal_cmd | self_offset_cal_cmd;
  // =========================
  // Command execution
  chk_pulse_single: assert property (any_p |=> !any_p)
    else $error("command pulse longer than one cycle");
  chk_cal_exclusive: assert property ($onehot0({dev_reset_pulse, system_offset_cal_cmd, gain_cal_cmd,
    self_offset_cal_cmd})) else $error("two command pulses together");
  chk_exec_in_frame: assert property (any_p |-> $past(cs_n, 6) == 1'b0)
    else $error("command ran outside a frame");
  chk_conv_in_frame: assert property ($changed(converting) |-> $past(cs_n, 6) == 1'b0)
    else $error("conversion state moved outside a frame");
  chk_reset_stops: assert property (dev_reset_pulse |-> ##[0:2] !converting)
    else $error("reset command left conversions running");
  // =========================
  // Check code and output line
  chk_flag_crc_only: assert property ($rose(check_error_flag) |-> check_framing_enable)
    else $error("check error without framing");
  chk_flag_sticky: assert property ($fell(check_error_flag) |-> $past(check_error_clear) || dev_reset_pulse)
    else $error("check error flag dropped by itself");
  chk_first_ff: assert property ($fell(cs_n) ##1 (!cs_n && !sclk) [*7] ##1 (!cs_n && sclk) [*4]
    |-> serial_out_ready) else $error("first frame byte not all ones");
  chk_ready_on_done: assert property (cs_n [*4] ##0 conv_done ##1 cs_n [*3] |-> !serial_out_ready)
    else $error("ready not shown after new result");
  cover property (dev_reset_pulse);
  cover property (gain_cal_cmd);
  cover property ($rose(check_error_flag));
endmodule // cmd_decoder_props
bind serial_cmd_decoder cmd_decoder_props u_cmd_decoder_props (.sys_clk, .rst, .cs_n, .sclk,
  .serial_out_ready, .check_framing_enable, .check_error_clear, .conv_done, .dev_reset_pulse,
  .converting, .system_offset_cal_cmd, .gain_cal_cmd, .self_offset_cal_cmd, .check_error_flag);
`default_nettype wire

// file: testbench/host_model.sv
// Serial host model driving select, link clock and data
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Link pins toward the device
  output logic     cs_n,
  output logic     sclk,
  output logic     din,
  // Answer line from the device
  input wire logic sdo
);
  int half = 400;  // Half link period in ns, raised for a slow host
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // One byte MSB first; answer read just before the next rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din = tx[i];
      #(half);
      sclk = 1'b0;
      #(half);
      rx[i] = sdo;
    end
  endtask
  // Open or close a frame; released data line wanders
  task automatic sel(input logic on);
    if (on) begin
      #37 cs_n = 1'b0;
      #800;
    end else begin
      #800 cs_n = 1'b1;
      din = ~din;
      #1600;
    end
  endtask
endmodule // host_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/1ns
`default_nettype none
`include "cmd_decoder_defs.vh"
module tb_top;
  // =========================
  // Bench functions
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction
  function automatic logic [7:0] reg_val(input logic [4:0] a);
    return {~a[2:0], a};
  endfunction
  // =========================
  // Signals and state
  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  logic            check_framing_enable = 1'b0;
  logic            status_enable = 1'b0;
  logic            check_error_clear = 1'b0;
  logic            conv_done = 1'b0;
  logic [23:0]     conv_data = 24'h000000;
  logic [7:0]      status_byte = 8'h00;
  wire logic       cs_n, sclk, din, serial_out_ready, dev_reset_pulse, converting;
  wire logic       system_offset_cal_cmd, gain_cal_cmd, self_offset_cal_cmd, check_error_flag;
  wire logic [4:0] reg_rd_addr;
  wire logic [7:0] reg_rd_data = reg_val(reg_rd_addr);  // Register file stand-in
  int              fail_count = 0;
  int              checks_done = 0;
  int              pc[4] = '{0, 0, 0, 0};
  int              ec[4] = '{0, 0, 0, 0};
  logic [31:0]     rnd = 32'hF210;
  logic [7:0]      rsp[10];
  logic [7:0]      v;
  logic [4:0]      a;
  logic            econv = 1'b0;
  logic [23:0]     d0;
  logic [7:0]      ops[8] = '{`OP_START, `OP_STOP, `OP_START, `OP_RESET, `OP_SYS_OFS, `OP_GAIN_CAL, `OP_SELF_OFS, 8'h00};
  logic [4:0]      corner[4] = '{5'h00, 5'h12, 5'h13, 5'h1F};
  always #50 sys_clk = ~sys_clk;
  serial_cmd_decoder u_serial_cmd_decoder (.sys_clk, .rst, .cs_n, .sclk, .din, .serial_out_ready,
    .check_framing_enable, .status_enable, .check_error_clear, .conv_done, .conv_data, .status_byte,
    .reg_rd_addr, .reg_rd_data, .dev_reset_pulse, .converting, .system_offset_cal_cmd, .gain_cal_cmd,
    .self_offset_cal_cmd, .check_error_flag);
  host_model u_host_model (.cs_n, .sclk, .din, .sdo(serial_out_ready));
  // Count every command pulse
  always @(posedge sys_clk) begin
    pc[0] += (dev_reset_pulse === 1'b1);
    pc[1] += (system_offset_cal_cmd === 1'b1);
    pc[2] += (gain_cal_cmd === 1'b1);
    pc[3] += (self_offset_cal_cmd === 1'b1);
  end
  // =========================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic c, input logic s);
    @(posedge sys_clk);
    #1 check_framing_enable = c;
    status_enable = s;
  endtask
  task automatic conv(input logic [23:0] d, input logic [7:0] s);
    @(posedge sys_clk);
    #1 conv_data = d;
    status_byte = s;
    conv_done = 1'b1;
    @(posedge sys_clk);
    #1 conv_done = 1'b0;
  endtask
  // Command bytes, optional check code, then n answer bytes
  task automatic frame(input logic [7:0] op, input logic [7:0] arb, input int n, input logic bad);
    logic [7:0] c;
    logic [7:0] r;
    c = crc_b(crc_b(8'hFF, op), arb);
    u_host_model.sel(1'b1);
    u_host_model.xfer(op, r);
    chk(r, `BYTE_IDLE);
    u_host_model.xfer(arb, r);
    chk(r, op);
    if (check_framing_enable) begin
      u_host_model.xfer(bad ? ~c : c, r);
      chk(r, arb);
      u_host_model.xfer(8'h00, r);
      chk(r, bad ? ~c : c);
    end
    for (int i = 0; i < n; i++) u_host_model.xfer(8'h00, rsp[i]);
    u_host_model.sel(1'b0);
  endtask
  task automatic rd_data(input logic [23:0] d, input logic [7:0] s);
    logic [7:0] e[5];
    int n;
    logic [7:0] c;
    n = status_enable ? 4 : 3;
    e[0] = s;
    e[n - 3] = d[23:16];
    e[n - 2] = d[15:8];
    e[n - 1] = d[7:0];
    c = 8'hFF;
    for (int i = 0; i < n; i++) c = crc_b(c, e[i]);
    e[n] = c;
    if (check_framing_enable) n = n + 1;
    frame(`OP_READ_DATA, 8'h00, n, 1'b0);
    for (int i = 0; i < n; i++) chk(rsp[i], e[i]);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // =========================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int m = 0; m < 2; m++) begin
      cfg(m[0], 1'b0);
      foreach (ops[i]) begin
        rnd = nx(rnd);
        frame(ops[i], rnd[7:0], 0, 1'b0);
        case (ops[i])
          `OP_START: econv = 1'b1;
          `OP_STOP: econv = 1'b0;
          `OP_RESET: begin
            econv = 1'b0;
            ec[0]++;
          end
          `OP_SYS_OFS: ec[1]++;
          `OP_GAIN_CAL: ec[2]++;
          `OP_SELF_OFS: ec[3]++;
          default: econv = econv;
        endcase
        chk({7'h00, converting}, {7'h00, econv});
        for (int k = 0; k < 4; k++) chk(8'(pc[k]), 8'(ec[k]));
      end
    end
    frame(`OP_START, 8'h5A, 0, 1'b1);
    chk({6'h00, converting, check_error_flag}, 8'h01);
    @(posedge sys_clk);
    #1 check_error_clear = 1'b1;
    @(posedge sys_clk);
    #1 check_error_clear = 1'b0;
    @(posedge sys_clk);
    chk({7'h00, check_error_flag}, 8'h00);
    u_host_model.sel(1'b1);
    u_host_model.xfer(`OP_START, v);
    u_host_model.sel(1'b0);
    chk({7'h00, converting}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      cfg(m[0], m[1]);
      rnd = nx(rnd);
      conv(rnd[23:0], rnd[31:24]);
      repeat (4) @(posedge sys_clk);
      chk({7'h00, serial_out_ready}, 8'h00);
      rd_data(rnd[23:0], rnd[31:24]);
      chk({7'h00, serial_out_ready}, 8'h01);
    end
    cfg(1'b0, 1'b0);
    d0 = rnd[23:0];
    rnd = nx(rnd);
    fork
      frame(`OP_READ_DATA, 8'h00, 3, 1'b0);
      begin
        #3000;
        conv(rnd[23:0], rnd[31:24]);
      end
    join
    v = ({rsp[0], rsp[1], rsp[2]} === d0 || {rsp[0], rsp[1], rsp[2]} === rnd[23:0]) ? 8'h01 : 8'h00;
    chk(v, 8'h01);
    for (int m = 0; m < 12; m++) begin
      cfg(m[0], 1'b0);
      rnd = nx(rnd);
      a = (m < 8) ? corner[m >> 1] : rnd[20:16];
      u_host_model.half = m[1] ? 800 : 400;
      frame({`OP_REG_BASE, a}, rnd[15:8], 1 + m[0], 1'b0);
      v = (a < `REG_COUNT) ? reg_val(a) : 8'h00;
      chk(rsp[0], v);
      if (m[0]) chk(rsp[1], crc_b(8'hFF, v));
    end
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    #4000000;
    fail_count++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
